// ### hdl/bfd_pkg.sv
// Package: opcode classes, field positions and timing counts for the branch/flag/timing decoder
package bfd_pkg;

  // ----------------------------------------------------------------
  // Instruction word layout
  // ----------------------------------------------------------------
  localparam int unsigned INSTR_W   = 16;        // Instruction word width
  localparam int unsigned CLASS_MSB = 15;        // Operation class field
  localparam int unsigned CLASS_LSB = 12;
  localparam int unsigned DST_MSB   = 11;        // dest_reg_sel field
  localparam int unsigned DST_LSB   = 8;
  localparam int unsigned SRC_MSB   = 7;         // source_reg_sel field
  localparam int unsigned SRC_LSB   = 4;
  localparam int unsigned DISP_MSB  = 3;         // Memory displacement field
  localparam int unsigned DISP_LSB  = 0;
  localparam int unsigned BDISP_MSB = 7;         // Branch displacement field
  localparam int unsigned BDISP_LSB = 0;
  localparam int unsigned SEL_W     = 4;         // Register selector width

  typedef logic [3:0] bfd_class_t;               // Operation class type

  // ----------------------------------------------------------------
  // Operation classes
  // ----------------------------------------------------------------
  localparam bfd_class_t CL_ALU      = 4'h0;     // Arithmetic, flag untouched
  localparam bfd_class_t CL_BRF      = 4'h1;     // branch_if_false
  localparam bfd_class_t CL_BRF_DLY  = 4'h2;     // branch_if_false, delayed
  localparam bfd_class_t CL_BRT      = 4'h3;     // branch_if_true
  localparam bfd_class_t CL_BRT_DLY  = 4'h4;     // branch_if_true, delayed
  localparam bfd_class_t CL_LDB      = 4'h5;     // Load byte
  localparam bfd_class_t CL_LDW      = 4'h6;     // Load word
  localparam bfd_class_t CL_LDL      = 4'h7;     // Load longword
  localparam bfd_class_t CL_STB      = 4'h8;     // Store byte
  localparam bfd_class_t CL_STW      = 4'h9;     // Store word
  localparam bfd_class_t CL_STL      = 4'ha;     // Store longword
  localparam bfd_class_t CL_FLAG_CLR = 4'hb;     // flag_clear_instr
  localparam bfd_class_t CL_FLAG_SET = 4'hc;     // flag_set_instr
  localparam bfd_class_t CL_CMP      = 4'hd;     // Compare, flag from datapath
  localparam bfd_class_t CL_PRIV     = 4'he;     // Privileged system op
  localparam bfd_class_t CL_NOP      = 4'hf;     // No operation

  // ----------------------------------------------------------------
  // Operand size shifts and branch offset
  // ----------------------------------------------------------------
  localparam logic [1:0]  SZ_BYTE     = 2'h0;    // Scale by one
  localparam logic [1:0]  SZ_WORD     = 2'h1;    // Scale by two
  localparam logic [1:0]  SZ_LONG     = 2'h2;    // Scale by four
  localparam logic [31:0] BR_PC_OFS   = 32'h4;   // Branch base is pc plus this

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam int unsigned MIN_CYCLES      = 1;   // Cycles with no wait states
  localparam int unsigned CONT_STALL_CYC  = 1;   // Added for fetch/data contention
  localparam int unsigned LOAD_STALL_CYC  = 1;   // Added for load-use dependency
  localparam int unsigned CYC_W           = 4;   // Cycle count width

endpackage

// ### hdl/bfd_op_table.sv
// Operation class table: decode attributes for one instruction class
module bfd_op_table
  import bfd_pkg::*;
(
  input  wire bfd_pkg::bfd_class_t op_class_i,   // Operation class
  output logic                    is_branch_o,  // Conditional branch
  output logic                    branch_on_o,  // Flag value that takes branch
  output logic                    delayed_o,    // Delayed branch form
  output logic                    is_mem_o,     // Data memory access
  output logic                    is_load_o,    // Memory to register load
  output logic [1:0]              size_o,       // Operand size shift
  output logic                    priv_o,       // Privileged mode only
  output logic                    flag_def_o    // Defined flag result
);

  // ----------------------------------------------------------------
  // Attribute lookup
  // ----------------------------------------------------------------
  // Defaults first, then per-class overrides
  always_comb
  begin
    is_branch_o = 1'b0;
    branch_on_o = 1'b0;
    delayed_o   = 1'b0;
    is_mem_o    = 1'b0;
    is_load_o   = 1'b0;
    size_o      = SZ_BYTE;
    priv_o      = 1'b0;
    flag_def_o  = 1'b0;
    case (op_class_i)
      CL_BRF:      is_branch_o = 1'b1;
      CL_BRF_DLY:
      begin
        is_branch_o = 1'b1;
        delayed_o   = 1'b1;
      end
      CL_BRT:
      begin
        is_branch_o = 1'b1;
        branch_on_o = 1'b1;
      end
      CL_BRT_DLY:
      begin
        is_branch_o = 1'b1;
        branch_on_o = 1'b1;
        delayed_o   = 1'b1;
      end
      CL_LDB, CL_LDW, CL_LDL:
      begin
        is_mem_o  = 1'b1;
        is_load_o = 1'b1;
        size_o    = (op_class_i == CL_LDB) ? SZ_BYTE : (op_class_i == CL_LDW) ? SZ_WORD : SZ_LONG;
      end
      CL_STB, CL_STW, CL_STL:
      begin
        is_mem_o = 1'b1;
        size_o   = (op_class_i == CL_STB) ? SZ_BYTE : (op_class_i == CL_STW) ? SZ_WORD : SZ_LONG;
      end
      CL_FLAG_CLR, CL_FLAG_SET, CL_CMP: flag_def_o = 1'b1;
      CL_PRIV:     priv_o = 1'b1;
      default:     is_branch_o = 1'b0;   // Plain ops: no attributes
    endcase
  end

endmodule

// ### hdl/bfd_decoder.sv
// Decode stage: conditional branches, register selects, stalls, flag and privilege
// Function
// - branch_if_false taken only when flag is 0
// - branch_if_true taken only when flag is 1
// - 4-bit selectors pick registers 0 to 15
// - Cycle count is minimum, stalls add more
// - Stall on fetch and data access contention
// - Stall when next instruction uses load destination
// - Flag holds unless instruction defines it
// - Privileged-only instructions fault outside privileged mode
// - Scale displacement by operand size
module bfd_decoder
  import bfd_pkg::*;
#(
  parameter int unsigned CONT_STALL = CONT_STALL_CYC,   // Contention stall cycles
  parameter int unsigned LOAD_STALL = LOAD_STALL_CYC    // Load-use stall cycles
)
(
  input  wire logic                   clk_i,            // Clock, 100 MHz
  input  wire logic                   reset_i,          // Sync reset, active high
  input  wire logic                   instr_valid_i,    // Instruction word present
  input  wire logic [INSTR_W-1:0]     instr_i,          // Instruction word
  input  wire logic [31:0]            pc_i,             // Address of instruction
  input  wire logic                   fetch_req_i,      // Fetch uses path this cycle
  input  wire logic                   priv_mode_i,      // Core in privileged mode
  input  wire logic                   flag_result_i,    // Compare result from datapath
  output logic                        instr_ready_o,    // Instruction taken this cycle
  output logic                        stall_o,          // Decode held this cycle
  output logic                        issue_o,          // One-cycle issue pulse
  output logic [SEL_W-1:0]            src_sel_o,        // source_reg_sel
  output logic [SEL_W-1:0]            dst_sel_o,        // dest_reg_sel
  output logic                        branch_taken_o,   // Redirect program counter
  output logic                        branch_delayed_o, // Redirect after delay slot
  output logic [31:0]                 branch_target_o,  // Branch destination
  output logic                        mem_op_o,         // Data access issued
  output logic                        mem_load_o,       // Access is a load
  output logic [5:0]                  mem_disp_o,       // Scaled displacement
  output logic                        priv_fault_o,     // Privilege violation pulse
  output logic                        flag_o,           // Condition flag
  output logic [CYC_W-1:0]            exec_cycles_o     // Cycles spent on issued op
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Reported count is minimum plus detection cycle plus both stalls; it must not wrap
  if (CONT_STALL < 1 || LOAD_STALL < 1 || CONT_STALL + LOAD_STALL + MIN_CYCLES + 1 >= (1 << CYC_W))
  begin : g_bad_param
    $error("Stall counts must be at least one and fit the cycle counter");
  end

  // ----------------------------------------------------------------
  // Field extraction and class lookup
  // ----------------------------------------------------------------
  typedef enum logic { ST_RUN, ST_STALL } bfd_state_e;   // Stall sequencer states

  bfd_state_e       state_reg;        // Sequencer state
  logic [CYC_W-1:0] stall_cnt_reg;    // Stall cycles left
  logic [CYC_W-1:0] cyc_cnt_reg;      // Cycles on current word so far
  logic             bypass_reg;       // Stall served, issue without recheck
  logic             load_pend_reg;    // Last issued op was a load
  logic [SEL_W-1:0] load_dst_reg;     // Destination of that load
  logic             flag_reg;         // Condition flag in status_register
  bfd_class_t       op_class;         // Class of presented word
  logic [SEL_W-1:0] src_sel;          // Presented source selector
  logic [SEL_W-1:0] dst_sel;          // Presented destination selector
  logic             is_branch;        // Attributes from table
  logic             branch_on;
  logic             delayed;
  logic             is_mem;
  logic             is_load;
  logic [1:0]       size;
  logic             priv;
  logic             flag_def;
  logic             contend;          // Fetch and data access collide
  logic             load_use;         // Depends on previous load
  logic             issue;            // Word leaves decode this cycle
  logic             fault;            // Privilege violation on issue

  assign op_class = instr_i[CLASS_MSB:CLASS_LSB];
  assign src_sel  = instr_i[SRC_MSB:SRC_LSB];
  assign dst_sel  = instr_i[DST_MSB:DST_LSB];

  bfd_op_table u_op_table (
    .op_class_i  (op_class),
    .is_branch_o (is_branch),
    .branch_on_o (branch_on),
    .delayed_o   (delayed),
    .is_mem_o    (is_mem),
    .is_load_o   (is_load),
    .size_o      (size),
    .priv_o      (priv),
    .flag_def_o  (flag_def)
  );

  // ----------------------------------------------------------------
  // Hazard detection and handshake
  // ----------------------------------------------------------------
  assign contend  = is_mem && fetch_req_i;
  assign load_use = load_pend_reg && (src_sel == load_dst_reg || dst_sel == load_dst_reg);
  assign issue    = instr_valid_i && state_reg == ST_RUN && (bypass_reg || !(contend || load_use));
  assign instr_ready_o = issue;
  assign stall_o  = instr_valid_i && !issue;
  assign fault    = priv && !priv_mode_i;

  // ----------------------------------------------------------------
  // Stall sequencer
  // ----------------------------------------------------------------
  // Holds the word for the stall count, then lets it through once
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_reg     <= ST_RUN;
      stall_cnt_reg <= '0;
      bypass_reg    <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_RUN:
        begin
          if (issue)
            bypass_reg <= 1'b0;
          else if (instr_valid_i && !bypass_reg)
          begin
            // Contention and load-use stalls add up
            state_reg     <= ST_STALL;
            stall_cnt_reg <= CYC_W'((contend ? CONT_STALL : 0) + (load_use ? LOAD_STALL : 0) - 1);
          end
        end
        ST_STALL:
        begin
          if (stall_cnt_reg == '0)
          begin
            state_reg  <= ST_RUN;
            bypass_reg <= 1'b1;
          end
          else
            stall_cnt_reg <= stall_cnt_reg - 1'b1;
        end
        default: state_reg <= ST_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Cycle accounting
  // ----------------------------------------------------------------
  // Counts every cycle the word waits; issue reports minimum plus waits
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cyc_cnt_reg   <= '0;
      exec_cycles_o <= '0;
    end
    else if (issue)
    begin
      cyc_cnt_reg   <= '0;
      exec_cycles_o <= cyc_cnt_reg + CYC_W'(MIN_CYCLES);
    end
    else if (instr_valid_i)
      cyc_cnt_reg <= cyc_cnt_reg + 1'b1;
  end

  // ----------------------------------------------------------------
  // Load tracking
  // ----------------------------------------------------------------
  // Remembers only the instruction just issued
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      load_pend_reg <= 1'b0;
      load_dst_reg  <= '0;
    end
    else if (issue)
    begin
      load_pend_reg <= is_load && !fault;
      load_dst_reg  <= dst_sel;
    end
  end

  // ----------------------------------------------------------------
  // Condition flag
  // ----------------------------------------------------------------
  // Only flag-defining classes write it; all others leave it
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      flag_reg <= 1'b0;
    else if (issue && flag_def && !fault)
    begin
      case (op_class)
        CL_FLAG_CLR: flag_reg <= 1'b0;
        CL_FLAG_SET: flag_reg <= 1'b1;
        default:     flag_reg <= flag_result_i;
      endcase
    end
  end
  assign flag_o = flag_reg;

  // ----------------------------------------------------------------
  // Issue outputs
  // ----------------------------------------------------------------
  // Registered results of the issued word
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      issue_o          <= 1'b0;
      src_sel_o        <= '0;
      dst_sel_o        <= '0;
      branch_taken_o   <= 1'b0;
      branch_delayed_o <= 1'b0;
      branch_target_o  <= '0;
      mem_op_o         <= 1'b0;
      mem_load_o       <= 1'b0;
      mem_disp_o       <= '0;
      priv_fault_o     <= 1'b0;
    end
    else
    begin
      issue_o          <= issue;
      priv_fault_o     <= issue && fault;
      // Branch compares the flag with the class polarity
      branch_taken_o   <= issue && is_branch && (flag_reg == branch_on);
      branch_delayed_o <= issue && is_branch && delayed && (flag_reg == branch_on);
      mem_op_o         <= issue && is_mem;
      mem_load_o       <= issue && is_load;
      if (issue)
      begin
        src_sel_o       <= src_sel;
        dst_sel_o       <= dst_sel;
        branch_target_o <= pc_i + BR_PC_OFS
                           + {{23{instr_i[BDISP_MSB]}}, instr_i[BDISP_MSB:BDISP_LSB], 1'b0};
        mem_disp_o      <= 6'({2'h0, instr_i[DISP_MSB:DISP_LSB]} << size);
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_bf_not_taken: assert property (@(posedge clk_i) disable iff (reset_i)
    issue && (op_class == CL_BRF || op_class == CL_BRF_DLY) |=> branch_taken_o == !$past(flag_reg))
    else $error("branch_if_false outcome does not follow flag");
  a_bt_taken: assert property (@(posedge clk_i) disable iff (reset_i)
    issue && (op_class == CL_BRT || op_class == CL_BRT_DLY) |=> branch_taken_o == $past(flag_reg))
    else $error("branch_if_true outcome does not follow flag");
  a_sel_fields: assert property (@(posedge clk_i) disable iff (reset_i)
    issue_o |-> src_sel_o == $past(instr_i[7:4]) && dst_sel_o == $past(instr_i[11:8]))
    else $error("register selectors not taken from word");
  a_cycles_min: assert property (@(posedge clk_i) disable iff (reset_i)
    issue && cyc_cnt_reg == '0 |=> exec_cycles_o == 1)
    else $error("unstalled op not reported as minimum");
  a_cont_stall: assert property (@(posedge clk_i) disable iff (reset_i)
    instr_valid_i && state_reg == ST_RUN && !bypass_reg && contend && !load_use
      |-> !instr_ready_o ##1 stall_o ##1 instr_ready_o)
    else $error("contention stall not one cycle");
  a_load_use: assert property (@(posedge clk_i) disable iff (reset_i)
    issue_o && mem_load_o ##0 instr_valid_i && state_reg == ST_RUN && !bypass_reg
      && src_sel == dst_sel_o && !contend |-> stall_o ##2 instr_ready_o)
    else $error("load-use dependency not stalled");
  a_flag_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    !(issue && flag_def) |=> $stable(flag_o))
    else $error("flag changed by non-defining op");
  a_priv_fault: assert property (@(posedge clk_i) disable iff (reset_i)
    issue && op_class == CL_PRIV |=> priv_fault_o == !$past(priv_mode_i))
    else $error("privilege check wrong");
  a_disp_long: assert property (@(posedge clk_i) disable iff (reset_i)
    issue && op_class == CL_LDL |=> mem_disp_o == {$past(instr_i[3:0]), 2'b00})
    else $error("longword displacement not scaled by four");
  a_flag_set: assert property (@(posedge clk_i) disable iff (reset_i)
    issue && op_class == CL_FLAG_SET |=> flag_o ##1 (flag_o || $past(issue)))
    else $error("flag set failed");

  c_branch_taken: cover property (@(posedge clk_i) disable iff (reset_i) branch_taken_o && branch_delayed_o);
  c_load_use:     cover property (@(posedge clk_i) disable iff (reset_i) issue_o && mem_load_o ##1 stall_o);
  c_contention:   cover property (@(posedge clk_i) disable iff (reset_i) contend && stall_o);
  c_priv_fault:   cover property (@(posedge clk_i) disable iff (reset_i) priv_fault_o);

endmodule

// ### tb/bfd_fetch_model.sv
// Instruction source model: presents words and holds each one until the decoder takes it, giving up with 64 refused cycles counted
module bfd_fetch_model
  import bfd_pkg::*;
(
  input  wire logic               clk_i,          // Decoder clock
  input  wire logic               instr_ready_i,  // Word taken this cycle
  output logic                    instr_valid_o,  // Word present
  output logic [INSTR_W-1:0]      instr_o,        // Instruction word
  output logic [31:0]             pc_o            // Address of the word
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Idle state at time zero
  // ----------------------------------------------------------------
  initial
  begin
    instr_valid_o = 1'b0;
    instr_o       = '0;
    pc_o          = '0;
  end

  // Present a word, hold it until taken, count refused cycles; give up with 64 counted
  task automatic present(input logic [INSTR_W-1:0] word, input logic [31:0] addr, output int stalls);
    logic taken;
    stalls        = 0;
    instr_o       = word;
    pc_o          = addr;
    instr_valid_o = 1'b1;
    forever
    begin
      // Ready is settled mid-cycle, inputs do not move before the edge
      @(negedge clk_i);
      taken = (instr_ready_i === 1'b1);
      @(posedge clk_i);
      if (taken || stalls >= 64)
        break;
      stalls++;
    end
    #1;
  endtask

  // Release the word; lines show the inverse of the last value, not a stale copy
  task automatic idle();
    instr_valid_o = 1'b0;
    instr_o       = ~instr_o;
    pc_o          = ~pc_o;
  endtask
endmodule

// ### tb/testbench.sv
// Self-checking bench for the branch, flag and timing decoder
module testbench
  import bfd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Signals and bench state
  // ----------------------------------------------------------------
  logic clk_i, reset_i, instr_valid, fetch_req, priv_mode, flag_result;
  logic [INSTR_W-1:0] instr;
  logic [31:0]        pc, branch_target;
  logic instr_ready, stall, issue, branch_taken, branch_delayed, mem_op, mem_load, priv_fault, flag;
  logic [SEL_W-1:0]   src_sel, dst_sel;
  logic [5:0]         mem_disp;
  logic [CYC_W-1:0]   exec_cycles;
  int err_total, checks;
  logic flag_exp, prev_load;                      // Reference flag and load history
  logic [3:0] prev_dst;                           // Destination of last issued word

  bfd_decoder dut (.clk_i(clk_i), .reset_i(reset_i), .instr_valid_i(instr_valid), .instr_i(instr),
    .pc_i(pc), .fetch_req_i(fetch_req), .priv_mode_i(priv_mode), .flag_result_i(flag_result),
    .instr_ready_o(instr_ready), .stall_o(stall), .issue_o(issue), .src_sel_o(src_sel),
    .dst_sel_o(dst_sel), .branch_taken_o(branch_taken), .branch_delayed_o(branch_delayed),
    .branch_target_o(branch_target), .mem_op_o(mem_op), .mem_load_o(mem_load),
    .mem_disp_o(mem_disp), .priv_fault_o(priv_fault), .flag_o(flag), .exec_cycles_o(exec_cycles));

  bfd_fetch_model fm (.clk_i(clk_i), .instr_ready_i(instr_ready), .instr_valid_o(instr_valid),
    .instr_o(instr), .pc_o(pc));

  // ----------------------------------------------------------------
  // Clock and helpers
  // ----------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Compare one value and report at once
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Print counts and verdict, then stop
  task automatic conclude();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  function automatic logic is_load(input bfd_class_t c);
    return c inside {CL_LDB, CL_LDW, CL_LDL};
  endfunction

  function automatic logic is_mem(input bfd_class_t c);
    return is_load(c) || c inside {CL_STB, CL_STW, CL_STL};
  endfunction

  // Displacement scaled by one, two or four
  function automatic logic [5:0] disp_exp(input bfd_class_t c, input logic [3:0] d);
    if (c inside {CL_LDL, CL_STL})
      return {d, 2'b00};
    if (c inside {CL_LDW, CL_STW})
      return {1'b0, d, 1'b0};
    return {2'b00, d};
  endfunction

  // Only set, clear and compare define the flag
  function automatic logic flag_next(input bfd_class_t c, input logic res, input logic old);
    case (c)
      CL_FLAG_CLR: return 1'b0;
      CL_FLAG_SET: return 1'b1;
      CL_CMP:      return res;
      default:     return old;
    endcase
  endfunction

  // Refused edges: the detection cycle plus the stall cycles of each hazard present
  function automatic int stall_exp(input logic c, input logic l);
    if (!(c || l))
      return 0;
    return 1 + (c ? int'(CONT_STALL_CYC) : 0) + (l ? int'(LOAD_STALL_CYC) : 0);
  endfunction

  // Present one word and compare every result one cycle after it is taken, displacement for memory words only
  task automatic run_word(input logic [15:0] w, input logic [31:0] a, input logic [2:0] ctl);
    int stalls;
    bfd_class_t cl;
    logic hc, hl, tk;
    cl          = w[15:12];
    fetch_req   = ctl[2];
    priv_mode   = ctl[1];
    flag_result = ctl[0];
    hc = is_mem(cl) && ctl[2];
    hl = prev_load && (w[7:4] == prev_dst || w[11:8] == prev_dst);
    tk = (cl inside {CL_BRF, CL_BRF_DLY} && !flag_exp) || (cl inside {CL_BRT, CL_BRT_DLY} && flag_exp);
    fm.present(w, a, stalls);
    chk(issue, 1'b1);
    chk(stalls, stall_exp(hc, hl));
    chk(exec_cycles, MIN_CYCLES + stall_exp(hc, hl));
    chk(branch_taken, tk);
    chk(branch_delayed, tk && cl inside {CL_BRF_DLY, CL_BRT_DLY});
    chk(branch_target, a + BR_PC_OFS + {{23{w[7]}}, w[7:0], 1'b0});
    chk(src_sel, w[7:4]);
    chk(dst_sel, w[11:8]);
    chk(mem_op, is_mem(cl));
    chk(mem_load, is_load(cl));
    if (is_mem(cl))
      chk(mem_disp, disp_exp(cl, w[3:0]));
    chk(priv_fault, cl == CL_PRIV && !ctl[1]);
    flag_exp = flag_next(cl, ctl[0], flag_exp);
    chk(flag, flag_exp);
    prev_load = is_load(cl);
    prev_dst  = w[11:8];
  endtask

  // Reset with the source idle, then check cleared outputs
  task automatic do_reset(input int n);
    fm.idle();
    reset_i = 1'b1;
    repeat (n) @(posedge clk_i);
    #1;
    reset_i   = 1'b0;
    flag_exp  = 1'b0;
    prev_load = 1'b0;
    chk(flag, 1'b0);
    chk(issue, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Corner cases: word and {fetch_req, priv_mode, flag_result}
  // ----------------------------------------------------------------
  logic [15:0] cw [16] = '{16'hc000, 16'h1f80, 16'h4a7f, 16'hd001, 16'hd000, 16'h0ff0, 16'h2001, 16'h3002,
                           16'h7f0f, 16'h01f0, 16'h5300, 16'h8030, 16'he000, 16'he000, 16'hb000, 16'h6a0c};
  logic [2:0]  cc [16] = '{3'h4, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h0, 3'h0,
                           3'h0, 3'h4, 3'h4, 3'h4, 3'h0, 3'h2, 3'h0, 3'h0};

  initial
  begin
    err_total   = 0;
    checks      = 0;
    fetch_req   = 1'b0;
    priv_mode   = 1'b0;
    flag_result = 1'b0;
    void'($urandom(32'hfebe0810));
    do_reset(6);
    foreach (cw[i])
      run_word(cw[i], 32'h0000_1000 + 32'(i) * 2, cc[i]);
    do_reset(2);
    for (int i = 0; i < 400; i++)
      run_word(16'($urandom), 32'h0001_0000 + 32'(i) * 2, 3'($urandom));
    fm.idle();
    conclude();
  end

  // Watchdog against a hang in the handshake
  initial
  begin
    repeat (30000) @(posedge clk_i);
    err_total++;
    conclude();
  end
endmodule
